// >>> spc_cfg.svh
// Offsets, field positions, reset values and timing counts of the serial port config block
`ifndef SPC_CFG_SVH
`define SPC_CFG_SVH

// Register offsets
`define SPC_OFS_SETUP_A      12'h000
`define SPC_OFS_SETUP_B      12'h001
`define SPC_OFS_DEV_TYPE     12'h003
`define SPC_OFS_SERIAL_LO    12'h004
`define SPC_OFS_SERIAL_HI    12'h005
`define SPC_OFS_DIE_REV      12'h006
`define SPC_OFS_COMMIT       12'h00f

// Setup A field positions (upper half, mirror is bit 7 - pos)
`define SPC_A_SOFT_RESET     3'd7
`define SPC_A_LSB_FIRST      3'd6
`define SPC_A_ADDR_ASCEND    3'd5
`define SPC_A_SDO_ENABLE     3'd4

// Setup B field positions
`define SPC_B_READ_BUFFER    3'd5
`define SPC_B_LOGIC_RESET    3'd2

// Commit register field position
`define SPC_COMMIT_BIT       3'd0

// Reset values
`define SPC_SETUP_A_RST      8'h00
`define SPC_SETUP_B_RST      8'h00

// Read latency of the register port in clock cycles
`define SPC_READ_LATENCY     1

`endif

// >>> spc_pkg.sv
// Types shared by the serial port config and identification block
package spc_pkg;
    typedef logic [7:0]  spc_byte_t;
    typedef logic [3:0]  spc_nibble_t;
    typedef logic [11:0] spc_serial_t;
endpackage

// >>> spc_regs.sv
// Serial port configuration registers and read-only identification registers
//
// Contract
// - Setup A bit 7 written one triggers full device reset, SPI mode only.
// - Bit 6 one shifts LSB first, zero MSB first; ignored in I2C.
// - Bit 5 one increments multibyte address, zero decrements; ignored in I2C.
// - Bit 4 one enables separate SDO pin, zero is 3-wire; ignored in I2C.
// - Setup A bits 3:0 mirror 7:4; each control is AND of pair.
// - Pairs fixed: 3 with 4, 2 with 5, 1 with 6, 0 with 7.
// - Setup B bit 5 selects buffered or active values on readback.
// - Setup B bit 2 one resets logic, keeps register contents.
// - Address 3 bits 3:0 read device type, upper bits zero.
// - Address 4 bits 7:4 read low part serial nibble, low bits zero.
// - Address 5 reads part serial bits 11:4.
// - Address 6 reads the eight-bit die revision.
// - Commit bit 0 at 0xf copies buffered values to active, self-clears.
`timescale 1ns/1ps
`include "spc_cfg.svh"

module spc_regs
    import spc_pkg::*;
#(
    parameter int          ADDR_W      = 12,
    parameter spc_nibble_t DEVICE_TYPE = 4'h9,    // Arbitrary neutral value
    parameter spc_serial_t PART_SERIAL = 12'h2a6, // Arbitrary neutral value
    parameter spc_byte_t   DIE_REV     = 8'h1c    // Arbitrary neutral value
) (
    // Clock and reset
    input  wire logic              clk_sys,
    input  wire logic              rst_n,
    // Port mode strap from a pin, high selects I2C
    input  wire logic              i2c_mode_pin,
    // Register access from the serial framing logic
    input  wire logic [ADDR_W-1:0] reg_addr,
    input  wire logic              reg_wr_en,
    input  wire logic [7:0]        reg_wdata,
    input  wire logic              reg_rd_en,
    output logic      [7:0]        reg_rdata,
    output logic                   reg_rd_valid,
    // Effective serial port controls
    output logic                   lsb_first,
    output logic                   addr_increment,
    output logic                   sdo_pin_enable,
    output logic                   readback_buffered,
    // Reset and commit pulses to the rest of the device
    output logic                   device_reset_pulse,
    output logic                   logic_reset_pulse,
    output logic                   commit_pulse
);

    // Refuse address widths that cannot reach the commit register
    generate
        if (ADDR_W < 4) begin : g_addr_check
            $error("spc_regs: ADDR_W must be at least 4");
        end
    endgenerate

    // Offset match, used by both the write and the read decode.
    // Both sides widen to 32 bits so upper address bits must be zero to match.
    function automatic logic hit(input logic [ADDR_W-1:0] addr, input logic [11:0] ofs);
        hit = (32'(addr) == 32'(ofs));
    endfunction

    // Reset release through two flops; assertion stays asynchronous
    logic rst_meta_reg;
    logic rst_sync_n_reg;
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            rst_meta_reg   <= 1'b0;
            rst_sync_n_reg <= 1'b0;
        end else begin
            rst_meta_reg   <= 1'b1;
            rst_sync_n_reg <= rst_meta_reg;
        end
    end

    // Mode pin synchroniser; only the second flop is read
    logic i2c_meta_reg;
    logic i2c_mode_reg;
    always_ff @(posedge clk_sys or negedge rst_sync_n_reg) begin
        if (!rst_sync_n_reg) begin
            i2c_meta_reg <= 1'b0;
            i2c_mode_reg <= 1'b0;
        end else begin
            i2c_meta_reg <= i2c_mode_pin;
            i2c_mode_reg <= i2c_meta_reg;
        end
    end

    // Setup B default, kept as a byte so its read buffer bit can be picked out
    localparam spc_byte_t SETUP_B_RST = `SPC_SETUP_B_RST;

    // Register state
    spc_byte_t setup_a_reg;
    spc_byte_t setup_a_next;
    logic      rdbuf_pend_reg;
    logic      rdbuf_pend_next;
    logic      rdbuf_act_reg;
    logic      rdbuf_act_next;
    logic      dev_rst_reg;
    logic      dev_rst_next;
    logic      log_rst_reg;
    logic      log_rst_next;
    logic      commit_reg;
    logic      commit_next;
    spc_byte_t rdata_reg;
    spc_byte_t rdata_next;
    logic      rd_valid_reg;
    logic      rd_valid_next;

    logic      wr_a;
    logic      wr_b;
    logic      wr_commit;
    logic      soft_reset_req;

    // Write decode; identification offsets have no write path at all
    always_comb begin
        wr_a           = reg_wr_en && hit(reg_addr, `SPC_OFS_SETUP_A);
        wr_b           = reg_wr_en && hit(reg_addr, `SPC_OFS_SETUP_B);
        wr_commit      = reg_wr_en && hit(reg_addr, `SPC_OFS_COMMIT);
        // Soft reset needs both paired bits and SPI mode
        soft_reset_req = wr_a && !i2c_mode_reg
                         && reg_wdata[`SPC_A_SOFT_RESET]
                         && reg_wdata[7 - `SPC_A_SOFT_RESET];
    end

    // Next-state for the configuration, buffer and pulse registers
    always_comb begin
        setup_a_next    = setup_a_reg;
        rdbuf_pend_next = rdbuf_pend_reg;
        rdbuf_act_next  = rdbuf_act_reg;
        dev_rst_next    = soft_reset_req;
        log_rst_next    = 1'b0;
        commit_next     = 1'b0;
        if (soft_reset_req) begin
            // Full reset returns Setup A and both read buffer bits to their defaults
            setup_a_next    = `SPC_SETUP_A_RST;
            rdbuf_pend_next = SETUP_B_RST[`SPC_B_READ_BUFFER];
            rdbuf_act_next  = SETUP_B_RST[`SPC_B_READ_BUFFER];
        end else begin
            if (wr_a) begin
                // Soft reset pair self-clears, the rest are stored
                setup_a_next = reg_wdata & 8'h7e;
            end
            if (wr_b) begin
                // Only bit 5 is stored; reserved bits are dropped
                rdbuf_pend_next = reg_wdata[`SPC_B_READ_BUFFER];
                // Logic reset leaves every register untouched
                log_rst_next    = reg_wdata[`SPC_B_LOGIC_RESET];
            end
            if (wr_commit && reg_wdata[`SPC_COMMIT_BIT]) begin
                // Staged value goes live; the strobe itself self-clears
                rdbuf_act_next = wr_b ? reg_wdata[`SPC_B_READ_BUFFER]
                                      : rdbuf_pend_reg;
                commit_next    = 1'b1;
            end
        end
    end

    // Read mux; reserved bits and unmapped offsets read as zero
    always_comb begin
        rd_valid_next = reg_rd_en;
        rdata_next    = 8'h00;
        if (reg_rd_en) begin
            if (hit(reg_addr, `SPC_OFS_SETUP_A)) begin
                rdata_next = setup_a_reg;
            end else if (hit(reg_addr, `SPC_OFS_SETUP_B)) begin
                // Buffered readback shows the staged bit, else the live one
                rdata_next[`SPC_B_READ_BUFFER] = rdbuf_act_reg ? rdbuf_pend_reg
                                                               : rdbuf_act_reg;
            end else if (hit(reg_addr, `SPC_OFS_DEV_TYPE)) begin
                rdata_next = {4'h0, DEVICE_TYPE};
            end else if (hit(reg_addr, `SPC_OFS_SERIAL_LO)) begin
                rdata_next = {PART_SERIAL[3:0], 4'h0};
            end else if (hit(reg_addr, `SPC_OFS_SERIAL_HI)) begin
                rdata_next = PART_SERIAL[11:4];
            end else if (hit(reg_addr, `SPC_OFS_DIE_REV)) begin
                rdata_next = DIE_REV;
            end else begin
                rdata_next = 8'h00;
            end
        end
    end

    // State registers, all cleared by the synchronised reset
    always_ff @(posedge clk_sys or negedge rst_sync_n_reg) begin
        if (!rst_sync_n_reg) begin
            setup_a_reg    <= `SPC_SETUP_A_RST;
            rdbuf_pend_reg <= 1'b0;
            rdbuf_act_reg  <= 1'b0;
            dev_rst_reg    <= 1'b0;
            log_rst_reg    <= 1'b0;
            commit_reg     <= 1'b0;
            rdata_reg      <= 8'h00;
            rd_valid_reg   <= 1'b0;
        end else begin
            setup_a_reg    <= setup_a_next;
            rdbuf_pend_reg <= rdbuf_pend_next;
            rdbuf_act_reg  <= rdbuf_act_next;
            dev_rst_reg    <= dev_rst_next;
            log_rst_reg    <= log_rst_next;
            commit_reg     <= commit_next;
            rdata_reg      <= rdata_next;
            rd_valid_reg   <= rd_valid_next;
        end
    end

    // Effective controls: AND of each pair, forced off in I2C mode; readback_buffered is the live bit alone, not gated.
    // A mismatched pair simply reads as off, which is the safe default.
    assign lsb_first = !i2c_mode_reg && setup_a_reg[`SPC_A_LSB_FIRST]
                       && setup_a_reg[7 - `SPC_A_LSB_FIRST];
    assign addr_increment = !i2c_mode_reg && setup_a_reg[`SPC_A_ADDR_ASCEND]
                            && setup_a_reg[7 - `SPC_A_ADDR_ASCEND];
    assign sdo_pin_enable = !i2c_mode_reg && setup_a_reg[`SPC_A_SDO_ENABLE]
                            && setup_a_reg[7 - `SPC_A_SDO_ENABLE];
    assign readback_buffered  = rdbuf_act_reg;

    // Pulses and read data
    assign device_reset_pulse = dev_rst_reg;
    assign logic_reset_pulse  = log_rst_reg;
    assign commit_pulse       = commit_reg;
    assign reg_rdata          = rdata_reg;
    assign reg_rd_valid       = rd_valid_reg;

endmodule

// >>> spc_regs_checker.sv
// Concurrent checks on the serial port setup and identification registers
`timescale 1ns/1ps
module spc_regs_checker
    import spc_pkg::*;
#(
    parameter int          ADDR_W      = 12,
    parameter spc_nibble_t DEVICE_TYPE = 4'h9,
    parameter spc_serial_t PART_SERIAL = 12'h2a6,
    parameter spc_byte_t   DIE_REV     = 8'h1c
) (
    // Clock, reset, mode pin and strobes
    input wire logic              clk_sys, rst_n, i2c_mode_pin, reg_wr_en, reg_rd_en,
    // Address and data
    input wire logic [ADDR_W-1:0] reg_addr,
    input wire logic [7:0]        reg_wdata, reg_rdata,
    // Outputs under watch
    input wire logic              reg_rd_valid, lsb_first, addr_increment, sdo_pin_enable,
    input wire logic              readback_buffered, device_reset_pulse, logic_reset_pulse,
    input wire logic              commit_pulse
);
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!rst_n);
    // Read data and its valid follow the strobe by one cycle
    property p_rd_lat; reg_rd_en |=> reg_rd_valid; endproperty
    a_rd_lat: assert property (p_rd_lat) else $error("read valid missing");
    property p_type; reg_rd_en && reg_addr == 3 |=> reg_rdata == {4'h0, DEVICE_TYPE}; endproperty
    a_type: assert property (p_type) else $error("device type wrong");
    property p_ser_lo; reg_rd_en && reg_addr == 4 |=> reg_rdata == {PART_SERIAL[3:0], 4'h0};
    endproperty
    a_ser_lo: assert property (p_ser_lo) else $error("serial low wrong");
    property p_ser_hi; reg_rd_en && reg_addr == 5 |=> reg_rdata == PART_SERIAL[11:4]; endproperty
    a_ser_hi: assert property (p_ser_hi) else $error("serial high wrong");
    property p_die; reg_rd_en && reg_addr == 6 |=> reg_rdata == DIE_REV; endproperty
    a_die: assert property (p_die) else $error("die revision wrong");
    // The synchronised mode seen at an edge is the pin as sampled two edges earlier
    property p_soft; reg_wr_en && reg_addr == 0 && reg_wdata[7] && reg_wdata[0]
        && !$past(i2c_mode_pin, 2) |=> device_reset_pulse; endproperty
    a_soft: assert property (p_soft) else $error("soft reset missing");
    property p_ctl; reg_wr_en && reg_addr == 0 && !(reg_wdata[7] && reg_wdata[0])
        && !$past(i2c_mode_pin, 1) |=> lsb_first == $past(reg_wdata[6]
        & reg_wdata[1]) && addr_increment == $past(reg_wdata[5] & reg_wdata[2]); endproperty
    a_ctl: assert property (p_ctl) else $error("bit pair gating wrong");
    property p_sdo; reg_wr_en && reg_addr == 0 && !(reg_wdata[7] && reg_wdata[0])
        && !$past(i2c_mode_pin, 1)
        |=> sdo_pin_enable == $past(reg_wdata[4] & reg_wdata[3]); endproperty
    a_sdo: assert property (p_sdo) else $error("sdo enable wrong");
    property p_i2c; $past(i2c_mode_pin, 2)
        |-> !lsb_first && !addr_increment && !sdo_pin_enable; endproperty
    a_i2c: assert property (p_i2c) else $error("controls live in i2c");
    property p_lrst; reg_wr_en && reg_addr == 1 && reg_wdata[2] |=> logic_reset_pulse; endproperty
    a_lrst: assert property (p_lrst) else $error("logic reset missing");
    property p_commit; reg_wr_en && reg_addr == 15 && reg_wdata[0] |=> commit_pulse; endproperty
    a_commit: assert property (p_commit) else $error("commit missing");
    c_commit: cover property (commit_pulse);
    c_soft: cover property (device_reset_pulse);
    c_all: cover property (lsb_first && addr_increment && sdo_pin_enable);
endmodule
bind spc_regs spc_regs_checker #(.ADDR_W(ADDR_W), .DEVICE_TYPE(DEVICE_TYPE),
    .PART_SERIAL(PART_SERIAL), .DIE_REV(DIE_REV)) spc_regs_checker_inst (.*);

// >>> spc_host_model.sv
// Host side model issuing single register strobes like the serial framing logic
`timescale 1ns/1ps
module spc_host_model #(parameter int ADDR_W = 12) (
    input  wire logic              clk_sys,
    input  wire logic [7:0]        reg_rdata,
    output logic      [ADDR_W-1:0] reg_addr,
    output logic                   reg_wr_en,
    output logic      [7:0]        reg_wdata,
    output logic                   reg_rd_en
);
    initial {reg_addr, reg_wr_en, reg_wdata, reg_rd_en} = '0;
    // Released lines show the inverse so stale values never pass for fresh ones
    task automatic wr(input logic [ADDR_W-1:0] a, input logic [7:0] d);
        @(posedge clk_sys);
        #1 {reg_addr, reg_wdata, reg_wr_en} = {a, d, 1'b1};
        @(posedge clk_sys);
        #1 {reg_addr, reg_wdata, reg_wr_en} = {~a, ~d, 1'b0};
    endtask
    // Data is taken the cycle after the strobe, while the valid pulse stands
    task automatic rd(input logic [ADDR_W-1:0] a, output logic [7:0] d);
        @(posedge clk_sys);
        #1 {reg_addr, reg_rd_en} = {a, 1'b1};
        @(posedge clk_sys);
        #1 d = reg_rdata;
        {reg_addr, reg_rd_en} = {~a, 1'b0};
    endtask
endmodule

// >>> test_serial_port_config_and_id_regs.sv
// Self-checking bench for the serial port setup and identification registers
`timescale 1ns/1ps
module test_serial_port_config_and_id_regs;
    import spc_pkg::*;
    localparam spc_nibble_t DT = 4'h6;   // Arbitrary identity value
    localparam spc_serial_t SN = 12'h3b5; // Arbitrary identity value
    localparam spc_byte_t   DR = 8'h42;  // Arbitrary identity value
    logic clk_sys = 1'b0, rst_n = 1'b0, i2c_mode_pin = 1'b0, wr_en, rd_en, rd_valid;
    logic lsb, inc, sdo, rb_buf, dev_rst, log_rst, commit;
    logic [11:0] addr;
    logic [7:0] wdata, rdata, rb;
    logic [2:0] n;
    int num_errors = 0, total_checks = 0;
    always #2 clk_sys = ~clk_sys;
    spc_regs #(.DEVICE_TYPE(DT), .PART_SERIAL(SN), .DIE_REV(DR)) spc_regs_inst (
        .clk_sys(clk_sys), .rst_n(rst_n), .i2c_mode_pin(i2c_mode_pin), .reg_addr(addr),
        .reg_wr_en(wr_en), .reg_wdata(wdata), .reg_rd_en(rd_en), .reg_rdata(rdata),
        .reg_rd_valid(rd_valid), .lsb_first(lsb), .addr_increment(inc), .sdo_pin_enable(sdo),
        .readback_buffered(rb_buf), .device_reset_pulse(dev_rst),
        .logic_reset_pulse(log_rst), .commit_pulse(commit));
    spc_host_model spc_host_model_inst (.clk_sys(clk_sys), .reg_rdata(rdata),
        .reg_addr(addr), .reg_wr_en(wr_en), .reg_wdata(wdata), .reg_rd_en(rd_en));
    task automatic end_sim;
        if (num_errors == 0 && total_checks > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask
    task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
        total_checks++;
        if (got !== exp) begin
            num_errors++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic chk1(input logic got, input logic exp);
        chk8({7'h00, got}, {7'h00, exp});
    endtask
    task automatic rdchk(input logic [11:0] a, input logic [7:0] exp);
        spc_host_model_inst.rd(a, rb);
        chk8(rb, exp);
        chk1(rd_valid, 1'b1);
    endtask
    // Setup A value with each mirror bit equal to its partner, soft reset clear
    function automatic logic [7:0] pair_a(input logic [2:0] v);
        return {1'b0, v, v[0], v[1], v[2], 1'b0};
    endfunction
    initial begin
        #20000;
        num_errors++;
        end_sim();
    end
    initial begin
        void'($urandom(12827));
        repeat (2) @(posedge clk_sys);
        #1 rst_n = 1'b1;
        repeat (3) @(posedge clk_sys);
        rdchk(12'h000, 8'h00);
        rdchk(12'h001, 8'h00);
        // Identity reads, then again after write attempts that must not stick
        for (int i = 0; i < 2; i++) begin
            for (int a = 3; a < 7 && i == 1; a++) spc_host_model_inst.wr(12'(a), 8'($urandom));
            rdchk(12'h003, {4'h0, DT});
            rdchk(12'h004, {SN[3:0], 4'h0});
            rdchk(12'h005, SN[11:4]);
            rdchk(12'h006, DR);
        end
        rdchk(12'h00f, 8'h00);
        rdchk(12'h007, 8'h00);
        for (int i = 0; i < 8; i++) begin
            n = (i == 0) ? 3'h7 : 3'($urandom);
            spc_host_model_inst.wr(12'h000, pair_a(n));
            chk1(lsb, n[2]);
            chk1(inc, n[1]);
            chk1(sdo, n[0]);
            rdchk(12'h000, pair_a(n));
        end
        spc_host_model_inst.wr(12'h000, 8'h72);
        chk8({5'h00, lsb, inc, sdo}, 8'h04);
        spc_host_model_inst.wr(12'h000, 8'h7e);
        spc_host_model_inst.wr(12'h001, 8'hff);
        chk1(log_rst, 1'b1);
        rdchk(12'h000, 8'h7e);
        rdchk(12'h001, 8'h00);
        spc_host_model_inst.wr(12'h00f, 8'h01);
        chk8({6'h00, commit, rb_buf}, 8'h03);
        rdchk(12'h001, 8'h20);
        spc_host_model_inst.wr(12'h001, 8'h00);
        rdchk(12'h001, 8'h00);
        chk1(rb_buf, 1'b1);
        @(posedge clk_sys);
        #1 i2c_mode_pin = 1'b1;
        repeat (4) @(posedge clk_sys);
        chk8({5'h00, lsb, inc, sdo}, 8'h00);
        spc_host_model_inst.wr(12'h000, 8'h81);
        chk1(dev_rst, 1'b0);
        @(posedge clk_sys);
        #1 i2c_mode_pin = 1'b0;
        repeat (4) @(posedge clk_sys);
        // Lone reset bit must not reset; the other pairs stay set so the reset shows
        spc_host_model_inst.wr(12'h000, 8'hfe);
        chk1(dev_rst, 1'b0);
        chk8({5'h00, lsb, inc, sdo}, 8'h07);
        spc_host_model_inst.wr(12'h000, 8'hff);
        chk1(dev_rst, 1'b1);
        chk8({5'h00, lsb, inc, sdo}, 8'h00);
        chk1(rb_buf, 1'b0);
        rdchk(12'h000, 8'h00);
        end_sim();
    end
endmodule
